/* bench/ioa_host_model.sv */
`timescale 1ns/1ns
module ioa_host_model
  import ioa_pkg::*;
(
  input  wire logic        sys_clk,
  output ioa_cmd_type      cmd,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic             cmd_standalone,
  input  wire logic        rsp_valid,
  output logic             rsp_ready,
  input  wire ioa_rsp_type rsp,
  input  wire logic        done
);
  // ************************************************************
  // idle levels at time zero
  // ************************************************************
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    cmd_standalone = 1'b0;
    rsp_ready = 1'b0;
  end

  // ************************************************************
  // one command frame, then its answer
  // ************************************************************
  // frame order
  // value carried as 32-bit two's complement
  // checksum over the first eight bytes
  task automatic issue(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                       input logic [31:0] val, input logic sa, input logic bad,
                       input int stall, output ioa_rsp_type got, output logic ans);
    ioa_cmd_type c;
    int          n;
    c.target = 8'h01;
    c.opcode = op;
    c.type_sel = typ;
    c.bank = bank;
    c.value = val;
    c.csum = c.target + op + typ + bank + val[31:24] + val[23:16] + val[15:8] + val[7:0];
    if (bad) c.csum = c.csum ^ 8'h5a; // deliberate corruption
    n = 0;
    @(negedge sys_clk);
    cmd = c;
    cmd_standalone = sa;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd = ~c; // released lines do not keep the old frame
    ans = sa ? done : rsp_valid;
    got = rsp;
    // hold the reply back for a while to test that it stands
    if (!sa && rsp_valid === 1'b1) begin
      repeat (stall) @(negedge sys_clk);
      got = rsp;
      rsp_ready = 1'b1;
      @(negedge sys_clk);
      rsp_ready = 1'b0;
    end
  endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) check_val(64'(g), 64'(e))
module tb;
  import ioa_pkg::*;
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   cmd_valid, cmd_ready, cmd_standalone, rsp_valid, rsp_ready, done;
  ioa_cmd_type            cmd;
  ioa_rsp_type            rsp, got;
  logic [GEN_IN_CNT-1:0]  gen_in_pin = '0;
  logic                   enc_near_zero_pin = 1'b0;
  logic [ADC_W-1:0]       adc_value = '0;
  logic [15:0]            supply_tenths = '0, temp_celsius = '0;
  logic [GEN_OUT_CNT-1:0] gen_out_state = '0;
  logic [31:0]            acc_value, acc_m, opv, ev;
  ioa_flags_type          flags, fe;
  ioa_jump_cond_type      jump_cond = JMP_ZE;
  logic                   jump_ok, ans;
  int                     seed = 8, mismatches = 0, check_count = 0, cycles = 0;
  logic [15:0]            rd_list [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h000b,
                                           16'h0100, 16'h0108, 16'h0109, 16'h0200, 16'h0201,
                                           16'h00ff};

  ioa_core u_ioa_core(.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_standalone(cmd_standalone),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .done(done),
    .gen_in_pin(gen_in_pin), .enc_near_zero_pin(enc_near_zero_pin), .adc_value(adc_value),
    .supply_tenths(supply_tenths), .temp_celsius(temp_celsius),
    .gen_out_state(gen_out_state), .acc_value(acc_value), .flags(flags),
    .jump_cond(jump_cond), .jump_ok(jump_ok));
  ioa_host_model u_ioa_host_model(.sys_clk(sys_clk), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_standalone(cmd_standalone), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .done(done));

  // ************************************************************
  // clock and hang guard
  // ************************************************************
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ************************************************************
  // comparison, verdict and expectation helpers
  // ************************************************************
  task automatic check_val(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] rsp_sum(input ioa_rsp_type r);
    return r.host + r.target + r.status + r.opcode + r.value[31:24] + r.value[23:16]
           + r.value[15:8] + r.value[7:0];
  endfunction
  function automatic logic [31:0] io_exp(input logic [7:0] bank, input logic [7:0] port);
    if (bank == 8'h00 && port == 8'h0b) return 32'(enc_near_zero_pin);
    if (bank == 8'h00 && port == 8'hff) return 32'(gen_in_pin);
    if (bank == 8'h00) return 32'(gen_in_pin[port[1:0]]);
    if (bank == 8'h02) return 32'(gen_out_state[port[0]]);
    if (port == 8'h08) return 32'(supply_tenths);
    if (port == 8'h09) return {{16{temp_celsius[15]}}, temp_celsius};
    return 32'(adc_value);
  endfunction
  function automatic logic [31:0] op_exp(input logic [31:0] a, input logic [31:0] b, input int t);
    case (t)
      0: return a + b;
      1: return a - b;
      2: return a * b;
      3: return (b == 0) ? a : 32'($signed(a) / $signed(b));
      4: return (b == 0) ? a : 32'($signed(a) % $signed(b));
      5: return a & b;
      6: return a | b;
      7: return a ^ b;
      8: return ~a;
      default: return b;
    endcase
  endfunction
  // one command through the host, with the common reply checks
  task automatic run(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                     input logic [31:0] val, input logic sa, input logic bad);
    u_ioa_host_model.issue(op, typ, bank, val, sa, bad, {$random(seed)} % 3, got, ans);
    `CHK(ans, 1'b1);
    if (!sa) begin
      `CHK({got.host, got.target, got.opcode}, {HOST_ADDR, 8'h01, op});
      `CHK(got.csum, rsp_sum(got));
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    `CHK(acc_value, 32'h0);
    acc_m = '0;
    // reads of every listed port with random pin levels
    for (int r = 0; r < 3; r++) begin
      @(negedge sys_clk);
      {enc_near_zero_pin, gen_in_pin, adc_value} = 17'($random(seed));
      {supply_tenths, temp_celsius} = 32'($random(seed));
      gen_out_state = 2'($random(seed));
      repeat (3) @(negedge sys_clk);
      foreach (rd_list[i]) begin
        run(OP_READ_IO, rd_list[i][7:0], rd_list[i][15:8], 32'h0, 1'b0, 1'b0);
        `CHK({got.status, got.value}, {STAT_OK, io_exp(rd_list[i][15:8], rd_list[i][7:0])});
        if (rd_list[i] == 16'h00ff) acc_m = 32'(gen_in_pin);
        `CHK(acc_value, acc_m);
      end
      // all inputs packed into the accumulator
      `CHK(acc_value, 32'(gen_in_pin));
      run(OP_READ_IO, PORT_ADC0, BANK_ANALOG, 32'h0, 1'b1, 1'b0);
      acc_m = 32'(adc_value);
      `CHK(acc_value, acc_m);
      `CHK(acc_value[31:12], 20'h0);
    end
    // every operation, with zero divisors and an illegal type
    for (int i = 0; i < 33; i++) begin
      opv = (i > 9 && i < 20 && (i % 10 == 3 || i % 10 == 4)) ? 32'h0 : $random(seed);
      if (i == 32) opv = 32'hffffec78;
      run(OP_ACCUMULATE, 8'(i % 10 + (i == 31 ? 10 : 0)), 8'h0, opv, i[0], 1'b0);
      if (i != 31) acc_m = op_exp(acc_m, opv, i % 10);
      `CHK(acc_value, acc_m);
      if (!i[0]) `CHK({got.status, got.value}, {STAT_OK, opv});
    end
    // load a negative operand, carried sign-extended
    run(OP_ACCUMULATE, ACC_LOAD, 8'h0, 32'hffffec78, 1'b0, 1'b0);
    acc_m = 32'hffffec78;
    `CHK(acc_value, 32'hffffec78);
    // illegal type, unknown opcode and unknown port answer with errors
    run(OP_ACCUMULATE, 8'h0a, 8'h0, 32'h5, 1'b0, 1'b0);
    `CHK({got.status, acc_value}, {STAT_BAD_TYPE, acc_m});
    run(8'h2a, 8'h0, 8'h0, 32'h5, 1'b0, 1'b0);
    `CHK({got.status, acc_value}, {STAT_BAD_OP, acc_m});
    run(OP_READ_IO, 8'h05, BANK_DIG_IN, 32'h77, 1'b0, 1'b0);
    `CHK({got.status, got.value}, {STAT_BAD_PORT, 32'h77});
    `CHK(acc_value, acc_m);
    // a corrupted frame leaves the accumulator alone
    run(OP_ACCUMULATE, 8'h09, 8'h0, 32'h1234, 1'b0, 1'b1);
    `CHK({got.status, acc_value}, {STAT_BAD_CSUM, acc_m});
    // compares against equal, random and neighbouring values, all jump tests
    for (int i = 0; i < 8; i++) begin
      opv = (i < 2) ? acc_m : (i < 4) ? acc_m + 32'(i * 2 - 5) : $random(seed);
      run(OP_COMPARE, 8'h0, 8'h0, opv, i[0], 1'b0);
      fe.zero = (acc_m == opv);
      fe.greater = ($signed(acc_m) > $signed(opv));
      fe.lower = ($signed(acc_m) < $signed(opv));
      `CHK({flags, acc_value}, {fe, acc_m});
      for (int c = 0; c < 8; c++) begin
        @(negedge sys_clk);
        jump_cond = ioa_jump_cond_type'(c[2:0]);
        ev = 32'({!fe.greater, fe.lower, !fe.lower, fe.greater,
                  !fe.zero, fe.zero, !fe.zero, fe.zero} >> c);
        #1 `CHK(jump_ok, ev[0]);
      end
    end
    summarize();
  end
endmodule

/* rtl/ioa_core.sv */
`timescale 1ns/1ns
module ioa_core
  import ioa_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire ioa_cmd_type            cmd,
  input  wire logic                   cmd_standalone,
  output logic                        rsp_valid,
  input  wire logic                   rsp_ready,
  output ioa_rsp_type                 rsp,
  output logic                        done,
  input  wire logic [GEN_IN_CNT-1:0]  gen_in_pin,
  input  wire logic                   enc_near_zero_pin,
  input  wire logic [ADC_W-1:0]       adc_value,
  input  wire logic [15:0]            supply_tenths,
  input  wire logic [15:0]            temp_celsius,
  input  wire logic [GEN_OUT_CNT-1:0] gen_out_state,
  output logic [31:0]                 acc_value,
  output ioa_flags_type               flags,
  input  wire ioa_jump_cond_type      jump_cond,
  output logic                        jump_ok
);

  // ************************************************************
  // helpers
  // ************************************************************
  // 8-bit sum of the first eight bytes of a frame
  function automatic logic [7:0] sum8(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + bytes[8*i +: 8];
    end
    return s;
  endfunction

  // accumulator arithmetic, signed 32-bit
  function automatic logic [31:0] acc_op(input ioa_acc_op_type op,
                                         input logic [31:0] a,
                                         input logic [31:0] b);
    logic [31:0] r;
    r = a;
    unique case (op)
      ACC_ADD:  r = a + b;
      ACC_SUB:  r = a - b;
      ACC_MUL:  r = 32'($signed(a) * $signed(b));
      ACC_DIV:  r = (b == 32'h0) ? a : 32'($signed(a) / $signed(b));
      ACC_MOD:  r = (b == 32'h0) ? a : 32'($signed(a) % $signed(b));
      ACC_AND:  r = a & b;
      ACC_OR:   r = a | b;
      ACC_XOR:  r = a ^ b;
      ACC_NOT:  r = ~a;
      ACC_LOAD: r = b;
      default:   r = a;
    endcase
    return r;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [GEN_IN_CNT-1:0] gin_s1_r, gin_s1_nxt, gin_r, gin_nxt;
  logic                  enc_s1_r, enc_s1_nxt, enc_r, enc_nxt;

  // two stages per pin
  always_comb begin
    gin_s1_nxt = gen_in_pin;
    gin_nxt    = gin_s1_r;
    enc_s1_nxt = enc_near_zero_pin;
    enc_nxt    = enc_s1_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gin_s1_r <= '0;
      gin_r    <= '0;
      enc_s1_r <= 1'b0;
      enc_r    <= 1'b0;
    end else begin
      gin_s1_r <= gin_s1_nxt;
      gin_r    <= gin_nxt;
      enc_s1_r <= enc_s1_nxt;
      enc_r    <= enc_nxt;
    end
  end

  // ************************************************************
  // port read mux
  // ************************************************************
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    unique case (cmd.bank)
      BANK_DIG_IN: begin
        if (cmd.type_sel < 8'(GEN_IN_CNT)) begin
          rd_val = {31'h0, gin_r[cmd.type_sel[1:0]]};
        end else if (cmd.type_sel == PORT_ALL_IN) begin
          rd_val = 32'(gin_r);
        end else if (cmd.type_sel == PORT_ENC_ZERO) begin
          rd_val = {31'h0, enc_r};
        end else begin
          rd_ok = 1'b0;
        end
      end
      BANK_ANALOG: begin
        if (cmd.type_sel == PORT_ADC0) begin
          rd_val = 32'(adc_value);
        end else if (cmd.type_sel == PORT_SUPPLY) begin
          rd_val = 32'(supply_tenths);
        end else if (cmd.type_sel == PORT_TEMP) begin
          rd_val = 32'($signed(temp_celsius));
        end else begin
          rd_ok = 1'b0;
        end
      end
      BANK_DIG_OUT: begin
        if (cmd.type_sel < 8'(GEN_OUT_CNT)) begin
          rd_val = {31'h0, gen_out_state[cmd.type_sel[0]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // command execution
  // ************************************************************
  logic          take;
  logic          csum_ok;
  logic [31:0]   acc_r, acc_nxt;
  ioa_flags_type flags_r, flags_nxt;
  ioa_rsp_type   rsp_r, rsp_nxt;
  logic          rsp_valid_r, rsp_valid_nxt;
  logic          done_r, done_nxt;
  logic [7:0]    st;
  logic [31:0]   val;

  assign cmd_ready = !rsp_valid_r;
  assign take      = cmd_valid && cmd_ready;
  assign csum_ok   = (sum8(cmd[71:8]) == cmd.csum);

  // next accumulator, flags and reply
  always_comb begin
    acc_nxt       = acc_r;
    flags_nxt     = flags_r;
    rsp_nxt       = rsp_r;
    rsp_valid_nxt = rsp_valid_r && !rsp_ready;
    done_nxt      = 1'b0;
    st            = STAT_OK;
    val           = cmd.value;
    if (take) begin
      if (!csum_ok) begin
        st = STAT_BAD_CSUM;
      end else begin
        unique case (cmd.opcode)
          OP_READ_IO: begin
            if (!rd_ok) begin
              st = STAT_BAD_PORT;
            end else begin
              val = rd_val;
              // direct leaves it, except packed inputs
              if (cmd_standalone || (cmd.bank == BANK_DIG_IN
                                     && cmd.type_sel == PORT_ALL_IN)) begin
                acc_nxt = rd_val;
              end
            end
          end
          OP_ACCUMULATE: begin
            if (cmd.type_sel > ACC_LOAD) begin
              st = STAT_BAD_TYPE;
            end else begin
              acc_nxt = acc_op(ioa_acc_op_type'(cmd.type_sel), acc_r, cmd.value);
            end
          end
          OP_COMPARE: begin
            flags_nxt.zero    = (acc_r == cmd.value);
            flags_nxt.greater = ($signed(acc_r) > $signed(cmd.value));
            flags_nxt.lower   = ($signed(acc_r) < $signed(cmd.value));
          end
          default: st = STAT_BAD_OP;
        endcase
      end
      rsp_nxt.host   = HOST_ADDR;
      rsp_nxt.target = cmd.target;
      rsp_nxt.status = st;
      rsp_nxt.opcode = cmd.opcode;
      rsp_nxt.value  = val;
      rsp_nxt.csum   = sum8({HOST_ADDR, cmd.target, st, cmd.opcode, val});
      rsp_valid_nxt  = !cmd_standalone;
      done_nxt       = cmd_standalone;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r       <= 32'h0;
      flags_r     <= '0;
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      acc_r       <= acc_nxt;
      flags_r     <= flags_nxt;
      rsp_r       <= rsp_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      done_r      <= done_nxt;
    end
  end

  assign acc_value = acc_r;
  assign flags     = flags_r;
  assign rsp       = rsp_r;
  assign rsp_valid = rsp_valid_r;
  assign done      = done_r;

  // ************************************************************
  // jump tests
  // ************************************************************
  // condition decode
  always_comb begin
    jump_ok = 1'b0;
    unique case (jump_cond)
      JMP_ZE, JMP_EQ: jump_ok = flags_r.zero;
      JMP_NZ, JMP_NE: jump_ok = !flags_r.zero;
      JMP_GT:         jump_ok = flags_r.greater;
      JMP_GE:         jump_ok = !flags_r.lower;
      JMP_LT:         jump_ok = flags_r.lower;
      JMP_LE:         jump_ok = !flags_r.greater;
    endcase
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_good_cmd(logic [7:0] op);
    take && csum_ok && cmd.opcode == op;
  endsequence

  sequence s_direct_reply;
    rsp_valid && rsp.status == STAT_OK;
  endsequence

  a_read_direct_value: assert property (s_good_cmd(OP_READ_IO) and rd_ok && !cmd_standalone
    |=> s_direct_reply and rsp.value == $past(rd_val))
    else $error("read reply value wrong");
  a_digital_in_range: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_DIG_IN
    && cmd.type_sel < 8'h04 |=> rsp_r.value == 32'($past(gin_r[cmd.type_sel[1:0]])))
    else $error("digital input read wrong");
  a_analog_in_range: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_ANALOG
    && cmd.type_sel == PORT_ADC0 |=> rsp_r.value <= 32'd4095)
    else $error("analog read out of range");
  a_standalone_acc: assert property (s_good_cmd(OP_READ_IO) and rd_ok && cmd_standalone
    |=> acc_r == $past(rd_val) && done)
    else $error("standalone read not in accumulator");
  a_direct_acc_kept: assert property (s_good_cmd(OP_READ_IO) and !cmd_standalone
    && cmd.type_sel != PORT_ALL_IN |=> $stable(acc_r))
    else $error("direct read changed accumulator");
  a_all_inputs_acc: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_DIG_IN
    && cmd.type_sel == PORT_ALL_IN |=> acc_r == 32'($past(gin_r)))
    else $error("packed inputs wrong");
  a_encoder_zero: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_DIG_IN
    && cmd.type_sel == PORT_ENC_ZERO |=> rsp_r.value == {31'h0, $past(enc_r)})
    else $error("encoder flag read wrong");
  a_supply_read: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_ANALOG
    && cmd.type_sel == PORT_SUPPLY |=> rsp_r.value == 32'($past(supply_tenths)))
    else $error("supply read wrong");
  a_output_readback: assert property (s_good_cmd(OP_READ_IO) and cmd.bank == BANK_DIG_OUT
    && cmd.type_sel == 8'h01 |=> rsp_r.value == {31'h0, $past(gen_out_state[1])})
    else $error("output read back wrong");
  a_acc_add: assert property (s_good_cmd(OP_ACCUMULATE) and cmd.type_sel == ACC_ADD
    |=> acc_r == $past(acc_r) + $past(cmd.value))
    else $error("add result wrong");
  a_acc_sub: assert property (s_good_cmd(OP_ACCUMULATE) and cmd.type_sel == ACC_SUB
    |=> acc_r == $past(acc_r) - $past(cmd.value))
    else $error("subtract result wrong");
  a_acc_reply: assert property (s_good_cmd(OP_ACCUMULATE) and !cmd_standalone
    && cmd.type_sel <= ACC_LOAD |=> s_direct_reply and rsp.value == $past(cmd.value))
    else $error("accumulate reply wrong");
  a_compare_flags: assert property (s_good_cmd(OP_COMPARE) |=> flags_r.greater
    == ($signed($past(acc_r)) > $signed($past(cmd.value))) && $stable(acc_r))
    else $error("compare flags wrong");
  a_jump_ge: assert property (jump_cond == JMP_GE |-> jump_ok == (flags_r.zero
    || flags_r.greater))
    else $error("ge test wrong");
  a_reply_csum: assert property (rsp_valid |-> rsp.csum == sum8(rsp[71:8]))
    else $error("reply checksum wrong");
  a_reply_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("reply dropped early");
  a_div_zero: assert property (s_good_cmd(OP_ACCUMULATE) and cmd.value == 32'h0
    && (cmd.type_sel == ACC_DIV || cmd.type_sel == ACC_MOD) |=> $stable(acc_r))
    else $error("zero divide changed accumulator");

endmodule

/* rtl/ioa_pkg.sv */
package ioa_pkg;

  // ************************************************************
  // opcodes, status codes
  // ************************************************************
  localparam logic [7:0] OP_READ_IO    = 8'h0f;
  localparam logic [7:0] OP_ACCUMULATE = 8'h13;
  localparam logic [7:0] OP_COMPARE    = 8'h14;
  localparam logic [7:0] STAT_OK       = 8'h64;
  localparam logic [7:0] STAT_BAD_CSUM = 8'h01;
  localparam logic [7:0] STAT_BAD_OP   = 8'h02;
  localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
  localparam logic [7:0] STAT_BAD_PORT = 8'h04;
  localparam logic [7:0] HOST_ADDR     = 8'h02;

  // ************************************************************
  // banks and ports
  // ************************************************************
  localparam logic [7:0] BANK_DIG_IN   = 8'h00;
  localparam logic [7:0] BANK_ANALOG   = 8'h01;
  localparam logic [7:0] BANK_DIG_OUT  = 8'h02;
  localparam logic [7:0] PORT_ALL_IN   = 8'hff;
  localparam logic [7:0] PORT_ENC_ZERO = 8'h0b;
  localparam logic [7:0] PORT_ADC0     = 8'h00;
  localparam logic [7:0] PORT_SUPPLY   = 8'h08;
  localparam logic [7:0] PORT_TEMP     = 8'h09;
  localparam int         GEN_IN_CNT    = 4;
  localparam int         GEN_OUT_CNT   = 2;
  localparam int         ADC_W         = 12;

  // ************************************************************
  // operations and jump tests
  // ************************************************************
  typedef enum logic [7:0] {
    ACC_ADD = 8'h00, ACC_SUB = 8'h01, ACC_MUL = 8'h02, ACC_DIV = 8'h03,
    ACC_MOD = 8'h04, ACC_AND = 8'h05, ACC_OR = 8'h06, ACC_XOR = 8'h07,
    ACC_NOT = 8'h08, ACC_LOAD = 8'h09
  } ioa_acc_op_type;

  typedef enum logic [2:0] {
    JMP_ZE = 3'h0, JMP_NZ = 3'h1, JMP_EQ = 3'h2, JMP_NE = 3'h3,
    JMP_GT = 3'h4, JMP_GE = 3'h5, JMP_LT = 3'h6, JMP_LE = 3'h7
  } ioa_jump_cond_type;

  // ************************************************************
  // frames and flags
  // ************************************************************
  typedef struct packed {
    logic [7:0]  target;
    logic [7:0]  opcode;
    logic [7:0]  type_sel;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  csum;
  } ioa_cmd_type;

  typedef struct packed {
    logic [7:0]  host;
    logic [7:0]  target;
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [31:0] value;
    logic [7:0]  csum;
  } ioa_rsp_type;

  typedef struct packed {
    logic zero;
    logic greater;
    logic lower;
  } ioa_flags_type;

endpackage
